// ---- rtl/gpts_time_sync.sv ----
// time-of-day keeper fed by satellite pulse and sentences or by a network time master
// What this block does
// - serial input is 9600 baud, eight data bits, no parity, one stop
// - only recommended-minimum position sentences are acted on, others ignored
// - take time from field 1, status from field 2, date from field 9
// - xor characters between dollar and asterisk, compare with two hex digits
// - time updates only when status is A; V leaves time untouched
// - rising edge of the positive pulse marks the whole second
// - with phase lock on and time synced, rotor sits at set angle firing at each second
// - phase lock angle accepts integers 0 through 360 only
// - three selectable sources: satellite, network precision time, layer-2 profile
// - layer-2 profile uses hardware timestamps, L2 framing, peer delay
// - network mode is slave only and adopts master time unchecked
// - when the master disappears time keeps advancing on the local clock
// - power cycle clears the time of day until new synchronisation
`timescale 1ns/1ps
`include "gpts_regs.svh"
module gpts_time_sync #(
  parameter int unsigned CLK_HZ = `GPTS_CLK_HZ,
  parameter int unsigned SENT_CYC = `GPTS_SENT_CYC,
  parameter int unsigned PPS_MIN_CYC = `GPTS_PPS_MIN_CYC,
  parameter int unsigned PPS_MAX_CYC = `GPTS_PPS_MAX_CYC,
  parameter int unsigned BIT_CYC = `GPTS_BIT_CYC
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic gnss_serial_input_i,
  input wire logic gnss_second_pulse_input_i,
  input wire logic [1:0] source_sel_i,
  input wire logic net_hw_stamp_i,
  input wire gpts_pkg::gpts_net_s net_time_i,
  input wire logic lock_enable_i,
  input wire logic [8:0] lock_angle_i,
  output logic [63:0] seconds_o,
  output logic [31:0] nanos_o,
  output gpts_pkg::gpts_tod_s tod_o,
  output logic synced_o,
  output logic pps_width_err_o,
  output logic sentence_err_o,
  output logic [8:0] lock_angle_o,
  output logic lock_strobe_o,
  output logic net_slave_o,
  output logic net_peer_delay_o,
  output logic net_l2_o
);
  localparam int unsigned NS_STEP = 1000000000 / CLK_HZ;
  gpts_pkg::gpts_rx_e rx_state;
  gpts_pkg::gpts_parse_e p_state;
  logic [15:0] rx_cnt;
  logic [2:0] rx_bit, head_pos;
  logic [7:0] rx_shift, rx_byte, sum, sum_rx;
  logic rx_valid, head_ok, status_a, pend_valid, pps_d, pps_rise;
  logic [3:0] field, field_pos, hexval;
  logic [3:0] dig [12];
  gpts_pkg::gpts_tod_s pend_tod;
  logic [31:0] pps_cnt, since_pps, sub_cnt;
  // oversampled 8N1 receiver, mid-bit sampling; a framing error drops the byte
  always_ff @(posedge clk_i)
  begin
    rx_valid <= 1'b0;
    if (sys_rst_i)
    begin
      rx_state <= gpts_pkg::GPTS_RX_IDLE;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_byte <= 8'h00;
    end
    else
    begin
      unique case (rx_state)
        gpts_pkg::GPTS_RX_IDLE:
        begin
          rx_cnt <= 16'h0000;
          if (!gnss_serial_input_i)
            rx_state <= gpts_pkg::GPTS_RX_START;
        end
        gpts_pkg::GPTS_RX_START:
        begin
          rx_cnt <= rx_cnt + 16'h0001;
          if (rx_cnt == 16'(BIT_CYC / 2))
          begin
            rx_cnt <= 16'h0000;
            rx_bit <= 3'h0;
            rx_state <= gnss_serial_input_i ? gpts_pkg::GPTS_RX_IDLE : gpts_pkg::GPTS_RX_DATA;
          end
        end
        gpts_pkg::GPTS_RX_DATA:
        begin
          rx_cnt <= rx_cnt + 16'h0001;
          if (rx_cnt == 16'(BIT_CYC - 1))
          begin
            rx_cnt <= 16'h0000;
            rx_shift <= {gnss_serial_input_i, rx_shift[7:1]};
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == 3'(`GPTS_DATA_BITS - 1))
              rx_state <= gpts_pkg::GPTS_RX_STOP;
          end
        end
        gpts_pkg::GPTS_RX_STOP:
        begin
          rx_cnt <= rx_cnt + 16'h0001;
          if (rx_cnt == 16'(BIT_CYC - 1))
          begin
            rx_valid <= gnss_serial_input_i;
            rx_byte <= rx_shift;
            rx_state <= gpts_pkg::GPTS_RX_IDLE;
          end
        end
      endcase
    end
  end
  assign hexval = (rx_byte >= 8'h30 && rx_byte <= 8'h39) ? rx_byte[3:0] :
                  (rx_byte >= 8'h41 && rx_byte <= 8'h46) ? 4'(rx_byte[3:0] + 4'h9) : 4'h0;
  // sentence parser; header characters after the dollar are matched against RMC
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      p_state <= gpts_pkg::GPTS_P_HUNT;
      field <= 4'h0;
      field_pos <= 4'h0;
      head_pos <= 3'h0;
      head_ok <= 1'b0;
      sum <= 8'h00;
      sum_rx <= 8'h00;
      status_a <= 1'b0;
      pend_valid <= 1'b0;
      pend_tod <= '0;
      sentence_err_o <= 1'b0;
      dig <= '{default: 4'h0};
    end
    else
    begin
      if (pps_rise)
        pend_valid <= 1'b0;
      if (rx_valid)
      begin
        if (rx_byte == 8'h24)
        begin
          p_state <= gpts_pkg::GPTS_P_HEAD;
          head_pos <= 3'h0;
          head_ok <= 1'b1;
          sum <= 8'h00;
          field <= 4'h0;
          field_pos <= 4'h0;
          status_a <= 1'b0;
        end
        else
        begin
          unique case (p_state)
            gpts_pkg::GPTS_P_HUNT: ;
            gpts_pkg::GPTS_P_HEAD:
            begin
              sum <= sum ^ rx_byte;
              head_pos <= head_pos + 3'h1;
              // talker id is any two letters, then R M C, then comma
              if ((head_pos == 3'h2 && rx_byte != 8'h52) || (head_pos == 3'h3 && rx_byte != 8'h4d) ||
                  (head_pos == 3'h4 && rx_byte != 8'h43) || (head_pos == 3'h5 && rx_byte != 8'h2c))
                head_ok <= 1'b0;
              if (head_pos == 3'h5)
                p_state <= (head_ok && rx_byte == 8'h2c) ? gpts_pkg::GPTS_P_BODY : gpts_pkg::GPTS_P_HUNT;
            end
            gpts_pkg::GPTS_P_BODY:
            begin
              if (rx_byte == 8'h2a)
                p_state <= gpts_pkg::GPTS_P_SUM1;
              else
              begin
                sum <= sum ^ rx_byte;
                if (rx_byte == 8'h2c)
                begin
                  field <= field + 4'h1;
                  field_pos <= 4'h0;
                end
                else
                begin
                  field_pos <= field_pos + 4'h1;
                  if (field == 4'(`GPTS_FIELD_TIME - 1) && field_pos < 4'h6)
                    dig[field_pos] <= rx_byte[3:0];
                  if (field == 4'(`GPTS_FIELD_STATUS - 1) && field_pos == 4'h0)
                    status_a <= (rx_byte == 8'h41);
                  if (field == 4'(`GPTS_FIELD_DATE - 1) && field_pos < 4'h6)
                    dig[4'(field_pos + 4'h6)] <= rx_byte[3:0];
                end
              end
            end
            gpts_pkg::GPTS_P_SUM1:
            begin
              sum_rx[7:4] <= hexval;
              p_state <= gpts_pkg::GPTS_P_SUM2;
            end
            gpts_pkg::GPTS_P_SUM2:
            begin
              p_state <= gpts_pkg::GPTS_P_HUNT;
              sentence_err_o <= ({sum_rx[7:4], hexval} != sum);
              if ({sum_rx[7:4], hexval} == sum && status_a && !pps_rise)
              begin
                pend_valid <= 1'b1;
                pend_tod.hour <= 5'(dig[0]) * 5'h0a + 5'(dig[1]);
                pend_tod.min <= 6'(dig[2]) * 6'h0a + 6'(dig[3]);
                pend_tod.sec <= 6'(dig[4]) * 6'h0a + 6'(dig[5]);
                pend_tod.day <= 5'(dig[6]) * 5'h0a + 5'(dig[7]);
                pend_tod.month <= dig[8] * 4'ha + dig[9];
                pend_tod.year <= 7'(dig[10]) * 7'h0a + 7'(dig[11]);
              end
            end
            default: p_state <= gpts_pkg::GPTS_P_HUNT;
          endcase
        end
      end
    end
  end
  // second pulse width check and rising edge
  assign pps_rise = gnss_second_pulse_input_i && !pps_d;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      pps_d <= 1'b0;
      pps_cnt <= 32'h0000_0000;
      pps_width_err_o <= 1'b0;
    end
    else
    begin
      pps_d <= gnss_second_pulse_input_i;
      pps_cnt <= gnss_second_pulse_input_i ? pps_cnt + 32'h0000_0001 : 32'h0000_0000;
      if (pps_d && !gnss_second_pulse_input_i)
        pps_width_err_o <= (pps_cnt < PPS_MIN_CYC) || (pps_cnt > PPS_MAX_CYC);
    end
  end
  // time keeping: sentence ending within SENT_CYC after a pulse stamps the second that began at that pulse
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      seconds_o <= 64'h0000_0000_0000_0000;
      nanos_o <= 32'h0000_0000;
      sub_cnt <= 32'h0000_0000;
      since_pps <= 32'h0000_0000;
      tod_o <= '0;
      synced_o <= 1'b0;
      lock_strobe_o <= 1'b0;
    end
    else
    begin
      lock_strobe_o <= 1'b0;
      since_pps <= pps_rise ? 32'h0000_0000 : since_pps + 32'h0000_0001;
      if (source_sel_i != `GPTS_SRC_GNSS && net_time_i.valid &&
          (source_sel_i == `GPTS_SRC_PTP || net_hw_stamp_i))
      begin
        seconds_o <= net_time_i.seconds;
        nanos_o <= net_time_i.nanos;
        sub_cnt <= 32'(net_time_i.nanos / NS_STEP);
        synced_o <= 1'b1;
      end
      else if ((source_sel_i == `GPTS_SRC_GNSS && pps_rise) || sub_cnt == 32'(CLK_HZ - 1))
      begin
        sub_cnt <= 32'h0000_0000;
        nanos_o <= 32'h0000_0000;
        seconds_o <= seconds_o + 64'h0000_0000_0000_0001;
        lock_strobe_o <= lock_enable_i && synced_o;
      end
      else
      begin
        sub_cnt <= sub_cnt + 32'h0000_0001;
        nanos_o <= nanos_o + 32'(NS_STEP);
      end
      if (source_sel_i == `GPTS_SRC_GNSS && pend_valid && since_pps < SENT_CYC && !pps_rise)
      begin
        tod_o <= pend_tod;
        synced_o <= 1'b1;
      end
    end
  end
  // angle setting above range is refused and the last legal angle kept
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      lock_angle_o <= 9'h000;
      {net_slave_o, net_peer_delay_o, net_l2_o} <= 3'b000;
    end
    else
    begin
      if (lock_angle_i <= 9'(`GPTS_ANGLE_MAX))
        lock_angle_o <= lock_angle_i;
      net_slave_o <= (source_sel_i != `GPTS_SRC_GNSS);
      net_peer_delay_o <= (source_sel_i == `GPTS_SRC_GPTP);
      net_l2_o <= (source_sel_i == `GPTS_SRC_GPTP);
    end
  end
endmodule

// ---- rtl/gpts_regs.svh ----
// constants for the satellite second-pulse time synchronisation block
`ifndef GPTS_REGS_SVH
`define GPTS_REGS_SVH
`define GPTS_CLK_HZ 20000000
`define GPTS_BAUD 9600
`define GPTS_BIT_CYC ((`GPTS_CLK_HZ + `GPTS_BAUD / 2) / `GPTS_BAUD)
`define GPTS_DATA_BITS 8
`define GPTS_PPS_MIN_MS 20
`define GPTS_PPS_MAX_MS 200
`define GPTS_PPS_MIN_CYC ((`GPTS_CLK_HZ / 1000) * `GPTS_PPS_MIN_MS)
`define GPTS_PPS_MAX_CYC ((`GPTS_CLK_HZ / 1000) * `GPTS_PPS_MAX_MS)
`define GPTS_SENT_MS 500
`define GPTS_SENT_CYC ((`GPTS_CLK_HZ / 1000) * `GPTS_SENT_MS)
`define GPTS_ANGLE_MAX 360
`define GPTS_FIELD_TIME 1
`define GPTS_FIELD_STATUS 2
`define GPTS_FIELD_DATE 9
`define GPTS_SRC_GNSS 2'h0
`define GPTS_SRC_PTP 2'h1
`define GPTS_SRC_GPTP 2'h2
`endif

// ---- rtl/gpts_pkg.sv ----
// types for the satellite second-pulse time synchronisation block
package gpts_pkg;
  typedef enum logic [1:0] {
    GPTS_RX_IDLE = 2'b00,
    GPTS_RX_START = 2'b01,
    GPTS_RX_DATA = 2'b10,
    GPTS_RX_STOP = 2'b11
  } gpts_rx_e;
  typedef enum logic [2:0] {
    GPTS_P_HUNT = 3'b000,
    GPTS_P_HEAD = 3'b001,
    GPTS_P_BODY = 3'b010,
    GPTS_P_SUM1 = 3'b011,
    GPTS_P_SUM2 = 3'b100
  } gpts_parse_e;
  typedef struct packed {
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
    logic [4:0] day;
    logic [3:0] month;
    logic [6:0] year;
  } gpts_tod_s;
  typedef struct packed {
    logic valid;
    logic [63:0] seconds;
    logic [31:0] nanos;
  } gpts_net_s;
endpackage

// ---- dv/gpts_time_sync_props.sv ----
// port assertions for the time synchronisation block
`timescale 1ns/1ps
module gpts_props_chk #(
  parameter int unsigned PPS_MIN_CYC = 40,
  parameter int unsigned PPS_MAX_CYC = 400
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic gnss_serial_input_i,
  input wire logic gnss_second_pulse_input_i,
  input wire logic [1:0] source_sel_i,
  input wire gpts_pkg::gpts_net_s net_time_i,
  input wire logic [8:0] lock_angle_i,
  input wire logic [63:0] seconds_o,
  input wire logic [31:0] nanos_o,
  input wire gpts_pkg::gpts_tod_s tod_o,
  input wire logic synced_o,
  input wire logic pps_width_err_o,
  input wire logic [8:0] lock_angle_o,
  input wire logic lock_strobe_o,
  input wire logic net_slave_o,
  input wire logic net_peer_delay_o,
  input wire logic net_l2_o
);
  logic [31:0] hi_cnt;
  // counts sampled high cycles of the current pulse
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !gnss_second_pulse_input_i)
      hi_cnt <= 32'h0000_0000;
    else
      hi_cnt <= hi_cnt + 32'h0000_0001;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_pulse_edge;
    $rose(gnss_second_pulse_input_i) && source_sel_i == 2'h0 && !net_time_i.valid;
  endsequence
  sequence s_pulse_end;
    $fell(gnss_second_pulse_input_i) && source_sel_i == 2'h0;
  endsequence
  property p_pulse_sec;
    s_pulse_edge |=> nanos_o == 32'h0000_0000 && seconds_o == $past(seconds_o) + 64'h0000_0000_0000_0001;
  endproperty
  a_pulse_sec: assert property (p_pulse_sec) else $error("second not started at pulse edge");
  property p_width;
    s_pulse_end ##0 (hi_cnt < PPS_MIN_CYC - 1 || hi_cnt > PPS_MAX_CYC + 1) |-> ##[1:3] pps_width_err_o;
  endproperty
  a_width: assert property (p_width) else $error("bad pulse width not flagged");
  property p_width_ok;
    s_pulse_end ##0 (hi_cnt > PPS_MIN_CYC + 1 && hi_cnt < PPS_MAX_CYC - 1) |-> ##[1:3] !pps_width_err_o;
  endproperty
  a_width_ok: assert property (p_width_ok) else $error("good pulse width flagged");
  property p_angle_max;
    lock_angle_o <= 9'h168;
  endproperty
  a_angle_max: assert property (p_angle_max) else $error("lock angle above limit");
  property p_angle_keep;
    lock_angle_i > 9'h168 |=> $stable(lock_angle_o);
  endproperty
  a_angle_keep: assert property (p_angle_keep) else $error("out of range angle taken");
  property p_strobe;
    lock_strobe_o |-> synced_o ##1 !lock_strobe_o;
  endproperty
  a_strobe: assert property (p_strobe) else $error("lock strobe unsynced or long");
  property p_ptp_load;
    net_time_i.valid && source_sel_i == 2'h1 |=> seconds_o == $past(net_time_i.seconds) && net_slave_o;
  endproperty
  a_ptp_load: assert property (p_ptp_load) else $error("master time not adopted");
  property p_l2_mode;
    source_sel_i == 2'h2 |=> net_l2_o && net_peer_delay_o && net_slave_o;
  endproperty
  a_l2_mode: assert property (p_l2_mode) else $error("layer-2 mode flags wrong");
  property p_tod_quiet;
    !$stable(tod_o) |-> gnss_serial_input_i && $past(gnss_serial_input_i, 2);
  endproperty
  a_tod_quiet: assert property (p_tod_quiet) else $error("time of day changed mid character");
endmodule
bind gpts_time_sync gpts_props_chk #(.PPS_MIN_CYC(PPS_MIN_CYC), .PPS_MAX_CYC(PPS_MAX_CYC)) chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .gnss_serial_input_i(gnss_serial_input_i),
  .gnss_second_pulse_input_i(gnss_second_pulse_input_i), .source_sel_i(source_sel_i),
  .net_time_i(net_time_i), .lock_angle_i(lock_angle_i), .seconds_o(seconds_o), .nanos_o(nanos_o),
  .tod_o(tod_o), .synced_o(synced_o), .pps_width_err_o(pps_width_err_o), .lock_angle_o(lock_angle_o),
  .lock_strobe_o(lock_strobe_o), .net_slave_o(net_slave_o), .net_peer_delay_o(net_peer_delay_o),
  .net_l2_o(net_l2_o)
);

// ---- dv/gpts_gnss_model.sv ----
// satellite receiver model: second pulse and serial sentences
`timescale 1ns/1ps
`include "gpts_regs.svh"
module gpts_gnss_model #(
  parameter int unsigned BIT_CYC = `GPTS_BIT_CYC
) (
  input wire logic clk_i,
  output logic ser_o,
  output logic pps_o
);
  initial
  begin
    ser_o = 1'b1;
    pps_o = 1'b0;
  end
  task automatic pulse(input int w);
    @(posedge clk_i);
    pps_o <= 1'b1;
    repeat (w) @(posedge clk_i);
    pps_o <= 1'b0;
  endtask
  task automatic tx(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      ser_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask
  function automatic logic [7:0] hexc(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction
  // bad flips the lowest checksum bit on purpose
  task automatic send(input string b, input bit bad);
    logic [7:0] x;
    x = 8'h00;
    tx(8'h24);
    for (int i = 0; i < b.len(); i++)
    begin
      tx(b[i]);
      x = x ^ b[i];
    end
    x = x ^ {7'h00, bad};
    tx(8'h2a);
    tx(hexc(x[7:4]));
    tx(hexc(x[3:0]));
  endtask
endmodule

// ---- dv/gpts_time_sync_bench.sv ----
// self-checking bench for the time synchronisation block
`timescale 1ns/1ps
module gpts_time_sync_bench;
  localparam int unsigned HZ = 4000;
  localparam int unsigned BIT = 8;
  localparam gpts_pkg::gpts_tod_s GOOD = '{5'h0c, 6'h22, 6'h38, 5'h0f, 4'h6, 7'h19};
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ser;
  logic pps;
  logic [1:0] src = 2'h0;
  logic stamp = 1'b0;
  gpts_pkg::gpts_net_s net = '0;
  logic lock_en = 1'b0;
  logic [8:0] angle = 9'h000;
  logic [63:0] secs;
  logic [31:0] nanos;
  gpts_pkg::gpts_tod_s tod;
  logic synced, w_err, s_err, strobe, slave, peer, l2;
  logic [8:0] angle_q;
  logic [63:0] s0;
  int mismatches = 0;
  int n_tests = 0;
  int strobes = 0;
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    if (strobe === 1'b1)
      strobes <= strobes + 1;
  end
  gpts_time_sync #(.CLK_HZ(HZ), .SENT_CYC(3500), .PPS_MIN_CYC(40), .PPS_MAX_CYC(400), .BIT_CYC(BIT)) uut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .gnss_serial_input_i(ser), .gnss_second_pulse_input_i(pps),
    .source_sel_i(src), .net_hw_stamp_i(stamp), .net_time_i(net), .lock_enable_i(lock_en),
    .lock_angle_i(angle), .seconds_o(secs), .nanos_o(nanos), .tod_o(tod), .synced_o(synced),
    .pps_width_err_o(w_err), .sentence_err_o(s_err), .lock_angle_o(angle_q), .lock_strobe_o(strobe),
    .net_slave_o(slave), .net_peer_delay_o(peer), .net_l2_o(l2)
  );
  gpts_gnss_model #(.BIT_CYC(BIT)) gm (.clk_i(clk_i), .ser_o(ser), .pps_o(pps));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic t_reset;
    sys_rst_i <= 1'b1;
    cyc(4);
    sys_rst_i <= 1'b0;
    cyc(2);
    check("seconds", secs, 64'h0);
    check("synced", synced, 1'b0);
    check("tod", tod, 33'h0);
    $display("test reset done");
  endtask
  task automatic t_pulse(input int w, input logic err);
    s0 = secs;
    gm.pulse(w);
    cyc(3);
    check("pulse second", secs, s0 + 64'h1);
    check("pulse nanos", nanos < (w + 6) * (1000000000 / HZ), 1'b1);
    check("pulse width", w_err, err);
    $display("test pulse %0d done", w);
  endtask
  task automatic t_period;
    s0 = secs;
    gm.pulse(100);
    cyc(HZ - 101);
    gm.pulse(100);
    check("second period", secs, s0 + 64'h2);
    check("period nanos", nanos < 102 * (1000000000 / HZ), 1'b1);
    $display("test period done");
  endtask
  task automatic t_late;
    gm.pulse(100);
    cyc(1000);
    gm.send("GPRMC,010101,A,,,,,,,020202,,,", 1'b0);
    cyc(5);
    check("late tod", tod, GOOD);
    check("late sentence err", s_err, 1'b0);
    $display("test late sentence done");
  endtask
  task automatic t_sent(input string b, input bit bad, input logic err);
    gm.pulse(100);
    gm.send(b, bad);
    cyc(5);
    check("tod", tod, GOOD);
    check("sentence err", s_err, err);
    check("synced", synced, 1'b1);
    $display("test sentence %s done", b);
  endtask
  task automatic t_lock;
    angle <= 9'h0c8;
    cyc(3);
    angle <= 9'h169;
    cyc(3);
    check("angle kept", angle_q, 9'h0c8);
    angle <= 9'h168;
    cyc(3);
    check("angle max", angle_q, 9'h168);
    strobes = 0;
    gm.pulse(100);
    check("strobe off", strobes, 0);
    lock_en <= 1'b1;
    gm.pulse(100);
    check("strobe on", strobes > 0, 1'b1);
    lock_en <= 1'b0;
    $display("test lock done");
  endtask
  task automatic net_load(input logic [1:0] s, input logic [63:0] t);
    src <= s;
    net <= '{1'b1, t, 32'h0000_0000};
    cyc(1);
    net.valid <= 1'b0;
    cyc(3);
  endtask
  task automatic t_net;
    net_load(2'h1, 64'h0000_0000_0001_2345);
    check("ptp load", secs, 64'h0000_0000_0001_2345);
    check("slave", slave, 1'b1);
    cyc(HZ + 10);
    check("holdover", secs, 64'h0000_0000_0001_2346);
    net_load(2'h2, 64'h0000_0000_0000_5555);
    check("no stamp", secs, 64'h0000_0000_0001_2346);
    stamp <= 1'b1;
    net_load(2'h2, 64'h0000_0000_0000_5555);
    check("l2 load", secs, 64'h0000_0000_0000_5555);
    check("l2 mode", {l2, peer}, 2'h3);
    net_load(2'h0, 64'h0000_0000_0000_7777);
    check("net ignored", secs, 64'h0000_0000_0000_5555);
    check("not slave", slave, 1'b0);
    stamp <= 1'b0;
    $display("test net done");
  endtask
  initial
  begin
    t_reset;
    t_pulse(20, 1'b1);
    t_pulse(100, 1'b0);
    t_pulse(500, 1'b1);
    t_period;
    t_sent("GPRMC,123456,A,,,,,,,150625,,,", 1'b0, 1'b0);
    t_sent("GPRMC,235959,A,,,,,,,311299,,,", 1'b1, 1'b1);
    t_sent("GPRMC,010203,V,,,,,,,010100,,,", 1'b0, 1'b0);
    t_sent("GPGGA,010203,A", 1'b0, 1'b0);
    t_late;
    t_lock;
    t_net;
    t_reset;
    stop_test;
  end
  initial
  begin
    #3_000_000;
    mismatches++;
    stop_test;
  end
endmodule
